// >>> logic/spot_axil_slave.sv
`timescale 1ns/1ps
module spot_axil_slave
	import spot_pkg::*;
(
	input  wire logic               i_ref_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_awvalid,
	output logic                    o_awready,
	input  wire logic [SPOT_AW-1:0] i_awaddr,
	input  wire logic               i_wvalid,
	output logic                    o_wready,
	input  wire logic [31:0]        i_wdata,
	input  wire logic [3:0]         i_wstrb,
	output logic                    o_bvalid,
	input  wire logic               i_bready,
	output logic [1:0]              o_bresp,
	input  wire logic               i_arvalid,
	output logic                    o_arready,
	input  wire logic [SPOT_AW-1:0] i_araddr,
	output logic                    o_rvalid,
	input  wire logic               i_rready,
	output logic [31:0]             o_rdata,
	output logic [1:0]              o_rresp,
	output logic                    o_wr_en,
	output logic [SPOT_IW-1:0]      o_wr_idx,
	output logic [31:0]             o_wr_data,
	output logic [SPOT_IW-1:0]      o_rd_idx,
	input  wire logic [31:0]        i_rd_data
);

	typedef struct packed {
		logic               aw_h;
		logic               w_h;
		logic [SPOT_AW-1:0] awaddr;
		logic [31:0]        wdata;
		logic               wlane0;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               ar_h;
		logic [SPOT_AW-1:0] araddr;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} spot_axi_s;

	spot_axi_s s;
	spot_axi_s next_s;

	// --------------------------------------------------------------
	// handshakes; a held address or data waits for its partner
	// --------------------------------------------------------------
	assign o_awready = !s.aw_h && !s.bvalid;
	assign o_wready  = !s.w_h && !s.bvalid;
	assign o_arready = !s.ar_h && !s.rvalid;
	assign o_bvalid  = s.bvalid;
	assign o_bresp   = s.bresp;
	assign o_rvalid  = s.rvalid;
	assign o_rdata   = s.rdata;
	assign o_rresp   = s.rresp;
	assign o_wr_idx  = s.awaddr[SPOT_AW-1:2];
	assign o_wr_data = s.wdata;
	assign o_rd_idx  = s.araddr[SPOT_AW-1:2];
	// unmapped or misaligned writes are dropped, answered with slverr
	assign o_wr_en   = s.aw_h && s.w_h && s.wlane0 && s.awaddr[1:0] == 2'h0 && spot_reg_hit(o_wr_idx);

	// next state of the slave
	always_comb begin
		next_s = s;
		if (i_awvalid && o_awready) begin
			next_s.aw_h   = 1'b1;
			next_s.awaddr = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			next_s.w_h    = 1'b1;
			next_s.wdata  = i_wdata;
			next_s.wlane0 = i_wstrb[0];
		end
		if (s.aw_h && s.w_h) begin
			next_s.aw_h   = 1'b0;
			next_s.w_h    = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = (s.awaddr[1:0] == 2'h0 && spot_reg_hit(o_wr_idx)) ? 2'h0 : 2'h2;
		end
		if (s.bvalid && i_bready)
			next_s.bvalid = 1'b0;
		if (i_arvalid && o_arready) begin
			next_s.ar_h   = 1'b1;
			next_s.araddr = i_araddr;
		end
		if (s.ar_h) begin
			next_s.ar_h   = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata  = i_rd_data;
			next_s.rresp  = (s.araddr[1:0] == 2'h0 && spot_reg_hit(o_rd_idx)) ? 2'h0 : 2'h2;
		end
		if (s.rvalid && i_rready)
			next_s.rvalid = 1'b0;
	end

	// state register
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			s <= '0;
		else
			s <= next_s;
	end

endmodule

// >>> logic/spot_pkg.sv
// Overview of operation
// - cell mode puts upstream cell bytes into envelope payload positions.
// - packet mode puts upstream packet bytes into payload of consecutive envelopes.
// - each envelope is 9 rows by 261 byte columns.
// - column one carries J1,B3,C2,G1,F2,H4,Z3,Z4,Z5 by row; rest is payload.
// - even BIP-8 over one envelope goes into B3 of the next.
// - B3 sent is computed parity XOR the error mask register.
// - error mask resets to zero; software leaves it zero unless testing.
// - AIS-P enable bit 0 forces every envelope byte to all-ones.
// - AIS-P enable also forces pointer bytes H1 H2 H3 to all-ones.
// - no cells or packets are sent while AIS-P is enabled.
// - automatic mode sends RDI-P while AIS/LOP/UNEQ/TIM/PLM path defect declared.
// - automatic mode sends RDI-P while loss of cell delineation declared.
// - RDI-P source is automatic, software value, or external overhead input.
// - automatic mode sends REI-P counts of received B3 errors.
// - software may instead dictate the REI-P value.
// - J1 repeats a path trace of 1, 16 or 64 bytes.
// - software forces a positive or negative pointer stuff.
// - software forces single or continuous new data flag events.
// - J1,C2,F2,H4,Z3,Z4,Z5 come from configuration; G1 is built from REI-P and RDI-P; H4 has no multiframe.
// - finished envelope stream goes to the downstream overhead processor.
// - automatic mode puts configured 3-bit defect code in G1 bits 5-7.
package spot_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int          SPOT_AW        = 16;
	localparam int          SPOT_IW        = 14;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [13:0] SPOT_IDX_CTRL0 = 14'h1983;
	localparam logic [13:0] SPOT_IDX_CFG   = 14'h1984;
	localparam logic [13:0] SPOT_IDX_C2    = 14'h1985;
	localparam logic [13:0] SPOT_IDX_F2    = 14'h1986;
	localparam logic [13:0] SPOT_IDX_H4    = 14'h1987;
	localparam logic [13:0] SPOT_IDX_Z3    = 14'h1988;
	localparam logic [13:0] SPOT_IDX_Z4    = 14'h1989;
	localparam logic [13:0] SPOT_IDX_Z5    = 14'h198a;
	localparam logic [13:0] SPOT_IDX_RDI   = 14'h198b;
	localparam logic [13:0] SPOT_IDX_REI   = 14'h198c;
	localparam logic [13:0] SPOT_IDX_PTR   = 14'h198d;
	localparam logic [13:0] SPOT_IDX_TRACE = 14'h198e;
	localparam logic [13:0] SPOT_IDX_STAT  = 14'h198f;
	localparam logic [13:0] SPOT_IDX_MASK  = 14'h1997;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          SPOT_CTRL_AIS  = 0;
	localparam int          SPOT_CTRL_C2T  = 2;
	localparam int          SPOT_CTRL_RDIT = 3;
	localparam int          SPOT_CTRL_REIT = 5;
	localparam int          SPOT_CTRL_F2T  = 7;
	localparam logic [7:0]  SPOT_CTRL_WMSK = 8'hfd;
	localparam int          SPOT_PTR_INC   = 0;
	localparam int          SPOT_PTR_DEC   = 1;
	localparam int          SPOT_PTR_NDF1  = 2;
	localparam int          SPOT_PTR_NDFC  = 3;
	localparam logic [7:0]  SPOT_RST_BYTE  = 8'h00;
	localparam logic [7:0]  SPOT_RST_MASK  = 8'h00;
	localparam logic [1:0]  SPOT_SRC_AUTO  = 2'h0;
	localparam logic [1:0]  SPOT_SRC_SW    = 2'h1;

	// ----------------------------------------------------------------
	// envelope geometry and fill
	// ----------------------------------------------------------------
	localparam logic [3:0]  SPOT_LAST_ROW  = 4'h8;
	localparam logic [8:0]  SPOT_LAST_COL  = 9'h104;
	localparam logic [7:0]  SPOT_FILL_CELL = 8'h00;
	localparam logic [7:0]  SPOT_FILL_PKT  = 8'h7e;
	localparam logic [7:0]  SPOT_ALL_ONES  = 8'hff;
	localparam logic [3:0]  SPOT_REI_MAX   = 4'h8;
	localparam logic [1:0]  SPOT_TRC_1     = 2'h0;
	localparam logic [1:0]  SPOT_TRC_16    = 2'h1;

	// true for every implemented register index
	function automatic logic spot_reg_hit(input logic [13:0] idx);
		spot_reg_hit = (idx >= SPOT_IDX_CTRL0 && idx <= SPOT_IDX_STAT) || idx == SPOT_IDX_MASK;
	endfunction

	// last trace index for the selected message length
	function automatic logic [5:0] spot_trace_last(input logic [1:0] sel);
		case (sel)
			SPOT_TRC_1:  spot_trace_last = 6'h00;
			SPOT_TRC_16: spot_trace_last = 6'h0f;
			default:     spot_trace_last = 6'h3f;
		endcase
	endfunction

endpackage

// >>> logic/spot_transmitter.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module spot_transmitter
	import spot_pkg::*;
(
	input  wire logic               i_ref_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_awvalid,
	output logic                    o_awready,
	input  wire logic [SPOT_AW-1:0] i_awaddr,
	input  wire logic [2:0]         i_awprot,
	input  wire logic               i_wvalid,
	output logic                    o_wready,
	input  wire logic [31:0]        i_wdata,
	input  wire logic [3:0]         i_wstrb,
	output logic                    o_bvalid,
	input  wire logic               i_bready,
	output logic [1:0]              o_bresp,
	input  wire logic               i_arvalid,
	output logic                    o_arready,
	input  wire logic [SPOT_AW-1:0] i_araddr,
	input  wire logic [2:0]         i_arprot,
	output logic                    o_rvalid,
	input  wire logic               i_rready,
	output logic [31:0]             o_rdata,
	output logic [1:0]              o_rresp,
	input  wire logic               i_pay_valid,
	input  wire logic [7:0]         i_pay_data,
	output logic                    o_pay_ready,
	input  wire logic               i_rx_ais_p,
	input  wire logic               i_rx_lop_p,
	input  wire logic               i_rx_uneq_p,
	input  wire logic               i_rx_tim_p,
	input  wire logic               i_rx_plm_p,
	input  wire logic               i_rx_lcd,
	input  wire logic               i_rx_b3_err_valid,
	input  wire logic [3:0]         i_rx_b3_err_cnt,
	input  wire logic [7:0]         i_external_path_overhead_input,
	input  wire logic               i_spe_req,
	output logic                    o_spe_valid,
	output logic [7:0]              o_spe_data,
	output logic                    o_spe_j1,
	output logic                    o_toh_ptr_ais,
	output logic                    o_ptr_inc,
	output logic                    o_ptr_dec,
	output logic                    o_ndf
);

	// --------------------------------------------------------------
	// state of the block
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0]       ctrl0;
		logic [7:0]       mask;
		logic [2:0]       cfg;
		logic [7:0]       c2;
		logic [7:0]       f2;
		logic [7:0]       h4;
		logic [7:0]       z3;
		logic [7:0]       z4;
		logic [7:0]       z5;
		logic [8:0]       rdi_codes;
		logic [3:0]       rei_sw;
		logic             inc_pend;
		logic             dec_pend;
		logic             ndf_pend;
		logic             ndf_cont;
		logic [63:0][7:0] trace;
		logic [5:0]       trace_idx;
		logic [3:0]       row;
		logic [8:0]       col;
		logic [7:0]       bip;
		logic [7:0]       b3;
		logic [3:0]       rei_acc;
		logic [7:0]       last_g1;
		logic [7:0]       ext_s1;
		logic [7:0]       ext_s2;
		logic             spe_valid;
		logic [7:0]       spe_data;
		logic             spe_j1;
		logic             ptr_inc;
		logic             ptr_dec;
		logic             ndf;
	} spot_main_s;

	spot_main_s s;
	spot_main_s next_s;

	logic               wr_en;
	logic [SPOT_IW-1:0] wr_idx;
	logic [31:0]        wr_data;
	logic [SPOT_IW-1:0] rd_idx;
	logic [31:0]        rd_data;
	logic               ais_on;
	logic               poh_col;
	logic               defect_path;
	logic [2:0]         rdi_code;
	logic [3:0]         rei_val;
	logic [7:0]         g1_byte;
	logic [7:0]         pay_byte;
	logic [4:0]         rei_sum;
	logic               j1_slot;
	logic               g1_slot;

	// --------------------------------------------------------------
	// register bus
	// --------------------------------------------------------------
	spot_axil_slave u_axil (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_awvalid (i_awvalid),
		.o_awready (o_awready),
		.i_awaddr  (i_awaddr),
		.i_wvalid  (i_wvalid),
		.o_wready  (o_wready),
		.i_wdata   (i_wdata),
		.i_wstrb   (i_wstrb),
		.o_bvalid  (o_bvalid),
		.i_bready  (i_bready),
		.o_bresp   (o_bresp),
		.i_arvalid (i_arvalid),
		.o_arready (o_arready),
		.i_araddr  (i_araddr),
		.o_rvalid  (o_rvalid),
		.i_rready  (i_rready),
		.o_rdata   (o_rdata),
		.o_rresp   (o_rresp),
		.o_wr_en   (wr_en),
		.o_wr_idx  (wr_idx),
		.o_wr_data (wr_data),
		.o_rd_idx  (rd_idx),
		.i_rd_data (rd_data)
	);

	// read mux; reserved bits and unused control bit 1 read as zero
	always_comb begin
		rd_data = 32'h0;
		case (rd_idx)
			SPOT_IDX_CTRL0: rd_data[7:0] = s.ctrl0;
			SPOT_IDX_CFG:   rd_data[2:0] = s.cfg;
			SPOT_IDX_C2:    rd_data[7:0] = s.c2;
			SPOT_IDX_F2:    rd_data[7:0] = s.f2;
			SPOT_IDX_H4:    rd_data[7:0] = s.h4;
			SPOT_IDX_Z3:    rd_data[7:0] = s.z3;
			SPOT_IDX_Z4:    rd_data[7:0] = s.z4;
			SPOT_IDX_Z5:    rd_data[7:0] = s.z5;
			SPOT_IDX_RDI:   rd_data[8:0] = s.rdi_codes;
			SPOT_IDX_REI:   rd_data[3:0] = s.rei_sw;
			SPOT_IDX_PTR:   rd_data[3:0] = {s.ndf_cont, s.ndf_pend, s.dec_pend, s.inc_pend};
			SPOT_IDX_TRACE: rd_data[13:8] = s.trace_idx;
			SPOT_IDX_STAT:  rd_data[11:0] = {s.rei_acc, s.last_g1};
			SPOT_IDX_MASK:  rd_data[7:0] = s.mask;
			default:        rd_data = 32'h0;
		endcase
	end

	// --------------------------------------------------------------
	// path overhead values
	// --------------------------------------------------------------
	assign ais_on      = s.ctrl0[SPOT_CTRL_AIS];
	assign poh_col     = (s.col == 9'h0);
	assign defect_path = i_rx_ais_p | i_rx_lop_p | i_rx_uneq_p | i_rx_tim_p | i_rx_plm_p;

	// rdi source select; auto chooses the code of the declared defect
	always_comb begin
		case (s.ctrl0[SPOT_CTRL_RDIT +: 2])
			SPOT_SRC_AUTO: begin
				if (defect_path)
					rdi_code = s.rdi_codes[2:0];
				else if (i_rx_lcd)
					rdi_code = s.rdi_codes[5:3];
				else
					rdi_code = 3'h0;
			end
			SPOT_SRC_SW: rdi_code = s.rdi_codes[8:6];
			default:     rdi_code = s.ext_s2[3:1];
		endcase
	end

	// rei: received error count in auto mode, else the software value
	assign rei_val = (s.ctrl0[SPOT_CTRL_REIT +: 2] == SPOT_SRC_AUTO) ? s.rei_acc : s.rei_sw;
	// g1 layout: rei in bits 1-4, rdi code in bits 5-7, spare bit 8
	assign g1_byte = {rei_val, rdi_code, 1'b0};

	// payload taken only at payload slots and never under ais
	assign o_pay_ready = i_spe_req && !poh_col && !ais_on;
	// starved source gets a neutral fill rather than stalling the line
	assign pay_byte = (i_pay_valid && o_pay_ready) ? i_pay_data : (s.cfg[0] ? SPOT_FILL_PKT : SPOT_FILL_CELL);

	// --------------------------------------------------------------
	// slot decode
	// --------------------------------------------------------------
	// one decode shared by the j1 marker and the once-per-envelope events; a second decode for the g1 capture
	assign j1_slot = poh_col && (s.row == 4'h0);
	assign g1_slot = poh_col && (s.row == 4'h3);

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		logic [7:0] b;
		logic       last;
		b            = 8'h0;
		last         = 1'b0;
		rei_sum      = 5'h0;
		next_s       = s;
		// two-flop stage for the overhead pins; only the second stage is read
		next_s.ext_s1    = i_external_path_overhead_input;
		next_s.ext_s2    = s.ext_s1;
		next_s.spe_valid = 1'b0;
		next_s.spe_j1    = 1'b0;
		next_s.ptr_inc   = 1'b0;
		next_s.ptr_dec   = 1'b0;
		next_s.ndf       = 1'b0;

		// envelope byte generation, one byte per request
		if (i_spe_req) begin
			if (poh_col) begin
				case (s.row)
					4'h0: b = s.trace[s.trace_idx];
					4'h1: b = s.b3 ^ s.mask;
					4'h2: b = s.ctrl0[SPOT_CTRL_C2T] ? s.ext_s2 : s.c2;
					4'h3: b = g1_byte;
					4'h4: b = s.ctrl0[SPOT_CTRL_F2T] ? s.ext_s2 : s.f2;
					4'h5: b = s.h4;
					4'h6: b = s.z3;
					4'h7: b = s.z4;
					default: b = s.z5;
				endcase
			end else begin
				b = pay_byte;
			end
			// ais overrides after the mux, so the parity still sees what leaves
			if (ais_on)
				b = SPOT_ALL_ONES;
			next_s.spe_data  = b;
			next_s.spe_valid = 1'b1;
			next_s.spe_j1    = j1_slot;

			// bip over every byte sent; moved into the next envelope's b3
			last = (s.row == SPOT_LAST_ROW) && (s.col == SPOT_LAST_COL);
			if (last) begin
				next_s.b3  = s.bip ^ b;
				next_s.bip = 8'h0;
			end else begin
				next_s.bip = s.bip ^ b;
			end

			// 9 x 261 walk, column first
			if (s.col == SPOT_LAST_COL) begin
				next_s.col = 9'h0;
				next_s.row = (s.row == SPOT_LAST_ROW) ? 4'h0 : s.row + 4'h1;
			end else begin
				next_s.col = s.col + 9'h1;
			end

			// once per envelope at j1: trace step and pointer events
			if (j1_slot) begin
				// a shortened message must not leave the index past its new end
				next_s.trace_idx = (s.trace_idx >= spot_trace_last(s.cfg[2:1])) ? 6'h0 : s.trace_idx + 6'h1;
				if (s.inc_pend) begin
					next_s.ptr_inc  = 1'b1;
					next_s.inc_pend = 1'b0;
				end else if (s.dec_pend) begin
					next_s.ptr_dec  = 1'b1;
					next_s.dec_pend = 1'b0;
				end
				next_s.ndf      = s.ndf_pend | s.ndf_cont;
				next_s.ndf_pend = 1'b0;
			end

			// g1 sent: remember it and restart the error count
			if (g1_slot) begin
				next_s.last_g1 = b;
				next_s.rei_acc = 4'h0;
			end
		end

		// received b3 errors add up; clamp at the largest legal rei
		if (i_rx_b3_err_valid) begin
			rei_sum = {1'b0, next_s.rei_acc} + {1'b0, i_rx_b3_err_cnt};
			next_s.rei_acc = (rei_sum > {1'b0, SPOT_REI_MAX}) ? SPOT_REI_MAX : rei_sum[3:0];
		end

		// software writes last, so a new command survives a same-cycle issue
		if (wr_en) begin
			case (wr_idx)
				SPOT_IDX_CTRL0: next_s.ctrl0 = wr_data[7:0] & SPOT_CTRL_WMSK;
				SPOT_IDX_CFG:   next_s.cfg = wr_data[2:0];
				SPOT_IDX_C2:    next_s.c2 = wr_data[7:0];
				SPOT_IDX_F2:    next_s.f2 = wr_data[7:0];
				SPOT_IDX_H4:    next_s.h4 = wr_data[7:0];
				SPOT_IDX_Z3:    next_s.z3 = wr_data[7:0];
				SPOT_IDX_Z4:    next_s.z4 = wr_data[7:0];
				SPOT_IDX_Z5:    next_s.z5 = wr_data[7:0];
				SPOT_IDX_RDI:   next_s.rdi_codes = wr_data[8:0];
				SPOT_IDX_REI:   next_s.rei_sw = wr_data[3:0];
				// a command written in its issuing cycle waits for the next envelope
				SPOT_IDX_PTR: begin
					next_s.inc_pend = s.inc_pend | wr_data[SPOT_PTR_INC];
					next_s.dec_pend = s.dec_pend | wr_data[SPOT_PTR_DEC];
					next_s.ndf_pend = next_s.ndf_pend | wr_data[SPOT_PTR_NDF1];
					next_s.ndf_cont = wr_data[SPOT_PTR_NDFC];
					if (next_s.ptr_inc)
						next_s.inc_pend = wr_data[SPOT_PTR_INC];
					if (next_s.ptr_dec)
						next_s.dec_pend = wr_data[SPOT_PTR_DEC];
				end
				SPOT_IDX_TRACE: next_s.trace[wr_data[13:8]] = wr_data[7:0];
				SPOT_IDX_MASK:  next_s.mask = wr_data[7:0];
				default: ;
			endcase
		end
	end

	// state register; everything clears, mask to zero
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			s       <= '0;
			s.mask  <= SPOT_RST_MASK;
			s.ctrl0 <= SPOT_RST_BYTE;
		end else begin
			s <= next_s;
		end
	end

	// --------------------------------------------------------------
	// outputs toward the overhead processor
	// --------------------------------------------------------------
	assign o_spe_valid   = s.spe_valid;
	assign o_spe_data    = s.spe_data;
	assign o_spe_j1      = s.spe_j1;
	assign o_toh_ptr_ais = ais_on;
	assign o_ptr_inc     = s.ptr_inc;
	assign o_ptr_dec     = s.ptr_dec;
	assign o_ndf         = s.ndf;

endmodule

// >>> sim/spot_far_end.sv
`timescale 1ns/1ps
module spot_far_end (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_run,
	input  wire logic       i_pay_ready,
	output logic            o_spe_req,
	output logic            o_pay_valid,
	output logic [7:0]      o_pay_data
);
	// downstream asks for one byte a cycle while running
	assign o_spe_req = i_run;

	// upstream source: counting bytes, always offered once out of reset
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_pay_valid <= 1'b0;
			o_pay_data  <= 8'h00;
		end else begin
			o_pay_valid <= 1'b1;
			if (o_pay_valid && i_pay_ready)
				o_pay_data <= o_pay_data + 8'h01;
		end
	end
endmodule

// >>> sim/spot_transmitter_assertions.sv
`timescale 1ns/1ps
module spot_transmitter_assertions
	import spot_pkg::*;
(
	input wire logic       i_ref_clk,
	input wire logic       i_rst_n,
	input wire logic       i_spe_req,
	input wire logic       o_pay_ready,
	input wire logic       o_spe_valid,
	input wire logic [7:0] o_spe_data,
	input wire logic       o_spe_j1,
	input wire logic       o_toh_ptr_ais,
	input wire logic       o_ptr_inc,
	input wire logic       o_ptr_dec,
	input wire logic       o_ndf
);
	// ----------------------------------------
	// slot position trackers
	// ----------------------------------------
	logic [11:0] n_val;
	logic [8:0]  col;

	// starts as if an envelope just ended, so the first byte must be j1
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			n_val <= 12'h92c;
			col   <= 9'h000;
		end else begin
			if (o_spe_valid)
				n_val <= o_spe_j1 ? 12'h000 : n_val + 12'h001;
			if (i_spe_req)
				col <= (col == 9'h104) ? 9'h000 : col + 9'h001;
		end
	end

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	a_spe_latency: assert property (i_spe_req |=> o_spe_valid) else $error("slot not answered");
	a_spe_no_extra: assert property (!i_spe_req |=> !o_spe_valid) else $error("byte without slot");
	a_j1_period: assert property (o_spe_valid |-> (o_spe_j1 == (n_val == 12'h92c))) else $error("j1 spacing");
	a_poh_no_pay: assert property (i_spe_req && col == 9'h000 |-> !o_pay_ready) else $error("payload in poh");
	a_pay_slot: assert property (i_spe_req && col != 9'h000 && !o_toh_ptr_ais |-> o_pay_ready)
		else $error("payload slot skipped");
	a_ais_no_pay: assert property (o_toh_ptr_ais |-> !o_pay_ready) else $error("payload under ais");
	a_ais_ones: assert property (o_spe_valid && $past(o_toh_ptr_ais) |-> o_spe_data == 8'hff)
		else $error("ais byte not ones");
	a_ptr_on_j1: assert property ((o_ptr_inc || o_ptr_dec || o_ndf) |-> o_spe_valid && o_spe_j1)
		else $error("pointer event off j1");

	c_inc: cover property (o_spe_j1 && o_ptr_inc);
	c_ais: cover property (o_spe_valid && o_toh_ptr_ais);
	c_poh: cover property (i_spe_req && col == 9'h000);
endmodule

bind spot_transmitter spot_transmitter_assertions spot_transmitter_assertions_i (.i_ref_clk, .i_rst_n,
	.i_spe_req, .o_pay_ready, .o_spe_valid, .o_spe_data, .o_spe_j1, .o_toh_ptr_ais, .o_ptr_inc, .o_ptr_dec, .o_ndf);

// >>> sim/spot_transmitter_tb.sv
`timescale 1ns/1ps
module spot_transmitter_tb
	import spot_pkg::*;
;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, plm = 0, ev = 0, run = 0;
	logic [15:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat, sd = 32'h800cc06d, d;
	logic [3:0]  ec = 0, ws = 4'hf;
	logic [7:0]  ext = 0, pc = 0, m, bp;
	logic [1:0]  r, bres, rres;
	logic        awr, wr_, bv, arr, rv, prdy, pv, sreq, sv, j1, ais, inc, dec, ndf;
	logic [7:0]  pd, sdat;
	logic [11:0] q[$];
	logic [12:0] ex;
	logic        pa = 0, lcd = 0;
	int          errors = 0, n_compared = 0;
	localparam int ROW[6] = '{2, 4, 5, 6, 7, 8};

	always #2.5 clk = ~clk;

	spot_transmitter spot_transmitter_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_awvalid(awv), .o_awready(awr),
		.i_awaddr(awa), .i_awprot(3'h0), .i_wvalid(wv), .o_wready(wr_), .i_wdata(wd), .i_wstrb(ws),
		.o_bvalid(bv), .i_bready(bre), .o_bresp(bres), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
		.i_arprot(3'h0), .o_rvalid(rv), .i_rready(rre), .o_rdata(rdat), .o_rresp(rres), .i_pay_valid(pv),
		.i_pay_data(pd), .o_pay_ready(prdy), .i_rx_ais_p(pa), .i_rx_lop_p(1'b0), .i_rx_uneq_p(1'b0),
		.i_rx_tim_p(1'b0), .i_rx_plm_p(plm), .i_rx_lcd(lcd), .i_rx_b3_err_valid(ev), .i_rx_b3_err_cnt(ec),
		.i_external_path_overhead_input(ext), .i_spe_req(sreq), .o_spe_valid(sv), .o_spe_data(sdat),
		.o_spe_j1(j1), .o_toh_ptr_ais(ais), .o_ptr_inc(inc), .o_ptr_dec(dec), .o_ndf(ndf));
	spot_far_end spot_far_end_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_pay_ready(prdy),
		.o_spe_req(sreq), .o_pay_valid(pv), .o_pay_data(pd));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic end_of_test();
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// each half released once taken; response waited for, not timed
	task automatic wr(input logic [13:0] x, input logic [31:0] v);
		@(posedge clk);
		awa <= {x, 2'b00}; wd <= v; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr_) wv <= 1'b0;
		end while (bv !== 1'b1);
		bre <= 1'b0;
	endtask

	task automatic rd(input logic [13:0] x, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk);
		ara <= {x, 2'b00}; arv <= 1'b1; rre <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		v = rdat; rs = rres; rre <= 1'b0;
	endtask

	// notes one envelope of expected {j1, inc, dec, ndf, byte}; returns its parity
	task automatic env(input logic [7:0] b3, g1, input logic a, input logic [2:0] pe, output logic [7:0] bip,
		input logic [7:0] poh[9]);
		logic [7:0] b;
		bip = 8'h00;
		for (int rw = 0; rw < 9; rw++)
			for (int c = 0; c < 261; c++) begin
				if (a) b = 8'hff;
				else if (c != 0) begin b = pc; pc++; end
				else b = (rw == 1) ? b3 : (rw == 3) ? g1 : poh[rw];
				bip ^= b;
				q.push_back({rw == 0 && c == 0, (rw == 0 && c == 0) ? pe : 3'h0, b});
			end
	endtask

	task automatic run_n(input int n);
		@(posedge clk);
		run <= 1'b1;
		repeat (n) @(posedge clk);
		run <= 1'b0;
	endtask

	// ----------------------------------------
	// stream monitor: oldest note against each byte
	// ----------------------------------------
	always @(posedge clk)
		if (sv === 1'b1) begin
			ex = (q.size() > 0) ? {1'b0, q.pop_front()} : 13'h1000;
			chk("spe", {20'h0, j1, inc, dec, ndf, sdat}, {19'h0, ex});
		end

	initial begin
		#200us;
		errors++;
		end_of_test();
	end

	initial begin
		logic [7:0] poh[9];
		poh = '{default: 8'h00};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(SPOT_IDX_MASK, d, r);
		chk("mask", d, 32'h0);
		rd(SPOT_IDX_CTRL0, d, r);
		chk("ctrl", d, 32'h0);
		rd(14'h1990, d, r);
		chk("rresp", {30'h0, r}, 32'h2);
		sd = lfsr(sd);
		m = sd[7:0];
		ext <= sd[15:8];
		wr(SPOT_IDX_MASK, {24'h0, m});
		rd(SPOT_IDX_MASK, d, r);
		chk("mask", d, {24'h0, m});
		// a write with byte lane 0 off is answered but must not land
		ws <= 4'he;
		wr(SPOT_IDX_MASK, 32'h0);
		ws <= 4'hf;
		rd(SPOT_IDX_MASK, d, r);
		chk("mask", d, {24'h0, m});
		for (int k = 0; k < 6; k++) begin
			wr(SPOT_IDX_C2 + 14'(k), 32'h21 + k);
			poh[ROW[k]] = 8'h21 + 8'(k);
		end
		// path defect code 5, delineation code 3; 3 errors before the first g1
		wr(SPOT_IDX_RDI, 32'h1d);
		wr(SPOT_IDX_PTR, 32'h1);
		@(posedge clk);
		pa <= 1'b1; ev <= 1'b1; ec <= 4'h3;
		@(posedge clk);
		ev <= 1'b0;
		env(m, 8'h3a, 1'b0, 3'h4, bp, poh);
		env(bp ^ m, 8'h06, 1'b0, 3'h0, bp, poh);
		run_n(2349);
		pa <= 1'b0;
		lcd <= 1'b1;
		run_n(2349);
		wr(SPOT_IDX_CTRL0, 32'h1);
		env(8'h00, 8'h00, 1'b1, 3'h0, bp, poh);
		run_n(2349);
		repeat (4) @(posedge clk);
		chk("ais", {31'h0, ais}, 32'h1);
		// path defect outranks delineation loss; negative stuff and one ndf
		plm <= 1'b1;
		wr(SPOT_IDX_CTRL0, 32'h0);
		wr(SPOT_IDX_PTR, 32'h6);
		env(bp ^ m, 8'h0a, 1'b0, 3'h3, bp, poh);
		run_n(2349);
		repeat (4) @(posedge clk);
		chk("left", q.size(), 32'h0);
		end_of_test();
	end
endmodule
